// *** logic/uart_line_status_pkg.sv ***
// Register map, field layout and defaults for the UART line status block
package uart_line_status_pkg;

  // Byte offsets on the register bus
  localparam logic [3:0] OFS_DATA        = 4'h0;
  localparam logic [3:0] OFS_CONTROL     = 4'h4;
  localparam logic [3:0] OFS_LINE_STATUS = 4'h8;

  // Control register fields
  localparam int CTRL_FIFO_EN  = 0;
  localparam int CTRL_HOLD_IE  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Line status fields
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN    = 1;
  localparam int LS_PARITY     = 2;
  localparam int LS_FRAMING    = 3;
  localparam int LS_BREAK      = 4;
  localparam int LS_HOLD_EMPTY = 5;
  localparam int LS_TX_EMPTY   = 6;
  localparam int LS_FIFO_ERR   = 7;

  // Receive entry layout: data in the low byte, error marks above
  localparam int ENTRY_W     = 11;
  localparam int ENTRY_PE    = 8;
  localparam int ENTRY_FE    = 9;
  localparam int ENTRY_BI    = 10;

  // Defaults for sizes and timing
  localparam int FIFO_DEPTH  = 16;
  localparam int BIT_CYCLES  = 868;
  localparam int FRAME_BITS  = 10;

endpackage

// *** logic/entry_fifo.sv ***
// Synchronous FIFO holding receive or transmit entries
`timescale 1ns/100ps
`default_nettype none

module entry_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic      [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("entry_fifo: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 count;
  } fifo_s;

  fifo_s s;
  fifo_s next_s;
  logic  push_ok;
  logic  pop_ok;

  always_comb begin
    next_s  = s;
    push_ok = push && (s.count != (AW+1)'(DEPTH));
    pop_ok  = pop && (s.count != '0);
    if (push_ok) begin
      next_s.mem[s.wr] = push_data;
      next_s.wr        = s.wr + 1'b1;
    end
    if (pop_ok) begin
      next_s.rd = s.rd + 1'b1;
    end
    next_s.count = s.count + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign head  = s.mem[s.rd];
  assign count = s.count;

endmodule

`default_nettype wire

// *** logic/uart_line_status.sv ***
// Line status logic of one UART channel with receive and transmit FIFOs
`timescale 1ns/100ps
`default_nettype none

module uart_line_status #(
  parameter int DEPTH      = uart_line_status_pkg::FIFO_DEPTH,
  parameter int BIT_CYCLES = uart_line_status_pkg::BIT_CYCLES,
  parameter int FRAME_BITS = uart_line_status_pkg::FRAME_BITS
) (
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Serial receive pin, watched for break
  input  wire logic        rx_line,
  // Character from the receive shifter, one-cycle pulse
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_char_parity_err,
  input  wire logic        rx_char_frame_err,
  // Character handed to the transmit shifter
  output logic             tx_char_valid,
  output logic      [7:0]  tx_char_data,
  input  wire logic        tx_char_ready,
  input  wire logic        shift_empty,
  // Transmit interrupt request, level
  output logic             tx_irq
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int EW = uart_line_status_pkg::ENTRY_W;

  initial begin
    if (BIT_CYCLES < 2 || BIT_CYCLES > 65535) begin
      $error("uart_line_status: BIT_CYCLES out of range");
    end
    if (FRAME_BITS < 7 || FRAME_BITS > 15) begin
      $error("uart_line_status: FRAME_BITS out of range");
    end
  end

  typedef struct packed {
    logic        rx_meta;
    logic        rx_sync;
    logic [15:0] bit_cnt;
    logic [3:0]  low_bits;
    logic        brk_armed;
    logic        fifo_en;
    logic        hold_ie;
    logic        overrun;
    logic        head_seen;
    logic        err_ack;
    logic [CW-1:0] err_count;
    logic        load_d;
    logic        ack;
    logic [31:0] rdata;
  } state_s;

  state_s s;
  state_s next_s;

  logic [EW-1:0] rx_head;
  logic [CW-1:0] rx_count;
  logic [7:0]    tx_head;
  logic [CW-1:0] tx_count;

  logic          rx_empty;
  logic          rx_full;
  logic          tx_empty;
  logic          tx_full;
  logic          accept;
  logic          rd_data;
  logic          rd_status;
  logic          wr_data;
  logic          brk_event;
  logic          push_req;
  logic [EW-1:0] push_entry;
  logic          rx_push;
  logic          rx_pop;
  logic          tx_push;
  logic          tx_pop;
  logic          push_err;
  logic          pop_err;
  logic          bit_tick;
  logic [2:0]    head_err;
  logic [7:0]    status;

  // FIFO depth collapses to one entry when FIFOs are off
  always_comb begin
    rx_empty = (rx_count == '0);
    tx_empty = (tx_count == '0);
    if (s.fifo_en) begin
      rx_full = (rx_count == CW'(DEPTH));
      tx_full = (tx_count == CW'(DEPTH));
    end else begin
      rx_full = !rx_empty;
      tx_full = !tx_empty;
    end
  end

  // Bus decode; side effects happen only on the accepting edge
  always_comb begin
    accept    = (read || write) && s.ack;
    rd_data   = accept && read && (address == uart_line_status_pkg::OFS_DATA);
    rd_status = accept && read
              && (address == uart_line_status_pkg::OFS_LINE_STATUS);
    wr_data   = accept && write && byteenable[0]
              && (address == uart_line_status_pkg::OFS_DATA);
  end

  // Break detection on the synchronised line
  always_comb begin
    bit_tick  = !s.rx_sync && (s.bit_cnt == 16'(BIT_CYCLES - 1));
    brk_event = bit_tick && s.brk_armed
              && (s.low_bits == 4'(FRAME_BITS - 1));
  end

  // Receive push selection and overrun
  always_comb begin
    push_req   = brk_event || rx_char_valid;
    push_entry = '0;
    if (brk_event) begin
      push_entry[uart_line_status_pkg::ENTRY_BI] = 1'b1;
    end else begin
      push_entry[7:0] = rx_char_data;
      push_entry[uart_line_status_pkg::ENTRY_FE] = rx_char_frame_err;
      push_entry[uart_line_status_pkg::ENTRY_PE] = rx_char_parity_err;
    end
    rx_push  = push_req && !rx_full;
    rx_pop   = rd_data && !rx_empty;
    push_err = rx_push && (push_entry[EW-1:8] != '0);
    pop_err  = rx_pop && (rx_head[EW-1:8] != '0);
  end

  // Transmit path
  always_comb begin
    tx_push       = wr_data && !tx_full;
    tx_char_valid = !tx_empty;
    tx_pop        = tx_char_valid && tx_char_ready;
    tx_char_data  = tx_head;
  end

  // Status word
  always_comb begin
    head_err = rx_head[EW-1:8] & {3{!s.head_seen && !rx_empty}};
    status   = '0;
    status[uart_line_status_pkg::LS_DATA_READY] = !rx_empty;
    status[uart_line_status_pkg::LS_OVERRUN]    = s.overrun;
    status[uart_line_status_pkg::LS_PARITY]     = head_err[0];
    status[uart_line_status_pkg::LS_FRAMING]    = head_err[1];
    status[uart_line_status_pkg::LS_BREAK]      = head_err[2];
    status[uart_line_status_pkg::LS_HOLD_EMPTY] = tx_empty;
    status[uart_line_status_pkg::LS_TX_EMPTY]   =
      tx_empty && shift_empty && !s.load_d;
    status[uart_line_status_pkg::LS_FIFO_ERR]   =
      (s.err_count != '0) && !s.err_ack;
  end

  always_comb begin
    next_s = s;

    // Two-stage synchroniser for the receive pin
    next_s.rx_meta = rx_line;
    next_s.rx_sync = s.rx_meta;

    // Bit-time divider runs only while the line is low
    if (s.rx_sync) begin
      next_s.bit_cnt   = '0;
      next_s.low_bits  = '0;
      next_s.brk_armed = 1'b1;
    end else if (bit_tick) begin
      next_s.bit_cnt = '0;
      if (s.low_bits != 4'(FRAME_BITS)) begin
        next_s.low_bits = s.low_bits + 4'h1;
      end
      if (brk_event) begin
        next_s.brk_armed = 1'b0;
      end
    end else begin
      next_s.bit_cnt = s.bit_cnt + 16'h1;
    end

    // Bus handshake: one wait cycle, read data captured during it
    next_s.ack = (read || write) && !s.ack;
    if (read && !s.ack) begin
      case (address)
        uart_line_status_pkg::OFS_DATA: begin
          next_s.rdata = {24'h0, rx_empty ? 8'h00 : rx_head[7:0]};
        end
        uart_line_status_pkg::OFS_CONTROL: begin
          next_s.rdata = '0;
          next_s.rdata[uart_line_status_pkg::CTRL_FIFO_EN] = s.fifo_en;
          next_s.rdata[uart_line_status_pkg::CTRL_HOLD_IE] = s.hold_ie;
        end
        uart_line_status_pkg::OFS_LINE_STATUS: begin
          next_s.rdata = {24'h0, status};
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end

    // Control register write; status writes fall through unused
    if (accept && write && byteenable[0]
        && address == uart_line_status_pkg::OFS_CONTROL) begin
      next_s.fifo_en = writedata[uart_line_status_pkg::CTRL_FIFO_EN];
      next_s.hold_ie = writedata[uart_line_status_pkg::CTRL_HOLD_IE];
    end

    // Overrun: a set in the clearing edge wins
    if (push_req && rx_full) begin
      next_s.overrun = 1'b1;
    end else if (rd_status
                 && s.rdata[uart_line_status_pkg::LS_OVERRUN]) begin
      next_s.overrun = 1'b0;
    end

    // Head error marks clear on a status read, rearm on a new head
    if (rx_pop) begin
      next_s.head_seen = 1'b0;
    end else if (rd_status && (s.rdata[4:2] != 3'h0)) begin
      next_s.head_seen = 1'b1;
    end

    // Count of stored entries carrying an error
    next_s.err_count = s.err_count + CW'(push_err) - CW'(pop_err);
    if (push_err) begin
      next_s.err_ack = 1'b0;
    end else if (rd_status
                 && s.rdata[uart_line_status_pkg::LS_FIFO_ERR]) begin
      next_s.err_ack = 1'b1;
    end

    // Shifter shows busy one cycle after a load
    next_s.load_d = tx_pop;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s           <= '0;
      s.rx_meta   <= 1'b1;
      s.rx_sync   <= 1'b1;
      s.brk_armed <= 1'b1;
      s.fifo_en   <= uart_line_status_pkg::CTRL_RESET[0];
      s.hold_ie   <= uart_line_status_pkg::CTRL_RESET[1];
    end else begin
      s <= next_s;
    end
  end

  assign readdata    = s.rdata;
  assign waitrequest = (read || write) && !s.ack;
  assign tx_irq      = tx_empty && s.hold_ie;

  entry_fifo #(
    .WIDTH (EW),
    .DEPTH (DEPTH)
  ) rx_fifo (
    .clk       (clk),
    .reset     (reset),
    .push      (rx_push),
    .push_data (push_entry),
    .pop       (rx_pop),
    .head      (rx_head),
    .count     (rx_count)
  );

  entry_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .push      (tx_push),
    .push_data (writedata[7:0]),
    .pop       (tx_pop),
    .head      (tx_head),
    .count     (tx_count)
  );

endmodule

`default_nettype wire

// *** verification/uart_line_status_chk.sv ***
// Port checker for the line status block
`timescale 1ns/100ps
`default_nettype none
module uart_line_status_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        tx_char_valid,
  input wire logic [7:0]  tx_char_data,
  input wire logic        tx_char_ready,
  input wire logic        shift_empty,
  input wire logic        tx_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic ls_done;
  logic tx_idle;
  assign ls_done = read && !waitrequest && address == 4'h8;
  assign tx_idle = shift_empty && !tx_char_valid;
  a_irq_empty: assert property (tx_irq |-> !tx_char_valid)
    else $error("irq while holding busy");
  a_thre_mirror: assert property (ls_done |->
    readdata[5] == !$past(tx_char_valid)) else $error("bit5 wrong");
  a_temt_busy: assert property (ls_done && !$past(tx_idle)
    |-> !readdata[6]) else $error("bit6 set while busy");
  a_temt_idle: assert property (ls_done && $past(tx_idle)
    && $past(tx_idle, 2) |-> readdata[6]) else $error("bit6 clear");
  a_upper_zero: assert property (read && !waitrequest
    |-> readdata[31:8] == 24'h0) else $error("upper bits set");
  a_tx_hold: assert property (tx_char_valid && !tx_char_ready
    |=> tx_char_valid && $stable(tx_char_data)) else $error("tx lost");
  a_load_busy: assert property (write && !waitrequest
    && byteenable[0] && address == 4'h0 && !tx_char_ready
    |=> tx_char_valid) else $error("write not held");
  a_wait_first: assert property ($rose(read || write)
    |-> waitrequest) else $error("no wait cycle");
  a_wait_one: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("wait too long");
  c_err_read: cover property (ls_done && readdata[7]);
  c_irq: cover property (tx_irq);
  c_pop: cover property (tx_char_valid && tx_char_ready);
endmodule
bind uart_line_status uart_line_status_chk chk_i (
  .clk(clk), .reset(reset), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .tx_char_valid(tx_char_valid),
  .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
  .shift_empty(shift_empty), .tx_irq(tx_irq));
`default_nettype wire

// *** verification/tx_shifter_model.sv ***
// Transmit shift register model on the far side of the block
`timescale 1ns/100ps
`default_nettype none
module tx_shifter_model #(
  parameter int SHIFT = 20
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       stall,
  input  wire logic       tx_char_valid,
  input  wire logic [7:0] tx_char_data,
  output logic            tx_char_ready,
  output logic            shift_empty = 1'b1
);
  logic [7:0] sent[$];
  int         cnt = 0;
  assign tx_char_ready = shift_empty && !stall;
  always @(posedge clk) begin
    if (reset) begin
      cnt <= 0;
      shift_empty <= 1'b1;
    end else if (tx_char_valid && tx_char_ready) begin
      sent.push_back(tx_char_data);
      cnt <= SHIFT;
      shift_empty <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      shift_empty <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the line status block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int D = 4;
  logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [3:0]  address = 4'h0, byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata, seed = 32'h75176c38;
  logic        waitrequest, rx_line = 1'b1, rx_char_valid = 1'b0;
  logic        rx_char_parity_err = 1'b0, rx_char_frame_err = 1'b0;
  logic [7:0]  rx_char_data = 8'h0, tx_char_data, rd;
  logic        tx_char_valid, tx_char_ready, shift_empty, tx_irq;
  logic        stall = 1'b0;
  logic [7:0]  rxq[$], txq[$];
  int          errors = 0, samples_checked = 0, cycles = 0, dep = 1;
  always #5 clk = ~clk;
  uart_line_status #(.DEPTH(D), .BIT_CYCLES(4), .FRAME_BITS(10)) uut (
    .clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .rx_line(rx_line),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_char_parity_err(rx_char_parity_err),
    .rx_char_frame_err(rx_char_frame_err), .tx_char_valid(tx_char_valid),
    .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
    .shift_empty(shift_empty), .tx_irq(tx_irq));
  tx_shifter_model shifter (
    .clk(clk), .reset(reset), .stall(stall), .tx_char_valid(tx_char_valid),
    .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
    .shift_empty(shift_empty));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic st(input logic [7:0] e);
    bus(1'b0, 4'h8, 8'h0);
    chk(rd, e);
  endtask
  task automatic pop();
    bus(1'b0, 4'h0, 8'h0);
    chk(rd, rxq.pop_front());
  endtask
  // Model drops a character that finds the receive side full
  task automatic rx(input logic [7:0] d, input logic pe, input logic fe);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_char_parity_err <= pe;
    rx_char_frame_err <= fe;
    if (rxq.size() < dep) rxq.push_back(d);
    @(posedge clk);
    rx_char_valid <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    st(8'h60);
    bus(1'b1, 4'h8, 8'hff);
    st(8'h60);
    bus(1'b0, 4'hc, 8'h0);
    chk(rd, 8'h0);
    $display("reset test done");
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 4'h4, {6'h0, 1'b1, m[0]});
      @(negedge clk) chk({7'h0, tx_irq}, 8'h1);
      stall <= 1'b1;
      for (int i = 0; i <= m; i++) begin
        txq.push_back(rnd());
        bus(1'b1, 4'h0, txq[$]);
      end
      st(8'h00);
      @(negedge clk) chk({7'h0, tx_irq}, 8'h0);
      stall <= 1'b0;
      while (shifter.sent.size() < txq.size()) @(posedge clk);
      st(8'h20);
      while (!shift_empty) @(posedge clk);
      st(8'h60);
    end
    foreach (txq[i]) chk(shifter.sent[i], txq[i]);
    $display("transmit test done");
    bus(1'b1, 4'h4, 8'h0);
    for (int k = 0; k < 2; k++) begin
      rx(rnd(), !k[0], k[0]);
      st(k[0] ? 8'he9 : 8'he5);
      st(8'h61);
      pop();
      st(8'h60);
    end
    $display("error flag test done");
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 4'h4, {7'h0, m[0]});
      dep = m ? D : 1;
      repeat (dep + 1) rx(rnd(), 1'b0, 1'b0);
      st(8'h63);
      while (rxq.size() > 0) pop();
      st(8'h60);
    end
    rx(rnd(), 1'b0, 1'b0);
    rx(rnd(), 1'b0, 1'b1);
    st(8'he1);
    pop();
    st(8'h69);
    pop();
    st(8'h60);
    $display("overrun and head test done");
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (100) @(posedge clk);
    rx_line <= 1'b1;
    rxq.push_back(8'h00);
    st(8'hf1);
    pop();
    st(8'h60);
    $display("break test done");
    give_verdict();
  end
endmodule
`default_nettype wire
